/* File: src/angle_sensor_end.sv */
// Summary of operation
// R01 - slave only; 16-bit word each way
// R02 - mode 3, rising-edge sample, MSB first
// R03 - master keeps select high 50 ns
// R04 - 50 ns from select low to clock
// R05 - clock period 40 ns, phases 20 ns; the master runs 240 ns phases, a 480 ns period
// R06 - 25 ns from last rise to select
// R07 - register 4 holds 8-bit zero offset
// R08 - register 9 bit 4 burns offset
// R09 - output is raw angle minus offset
// R10 - offset resets zero, feeds commutation too
// R11 - new front-end angle every 2 us
// R12 - angle from time-to-digital phase counter
// R13 - angle grows with clockwise field rotation
// R14 - write frame: 0010, address, value
// R15 - read frame returns angle then register
// R16 - buffer refreshed, frozen while selected
// R17 - master clock up to 25 MHz
// R18 - offset subtraction wraps modulo full turn
`timescale 1ns/1ps
`default_nettype none
module angle_sensor_end
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset
   spi_link_if.device link, // serial link to the master
   input wire logic phase_cross, // phase signal comparator, high after zero crossing
   input wire logic otp_valid, // fuse memory holds an offset
   input wire logic [angle_spi_pkg::ANGLE_W-1:0] otp_value, // offset held in fuses
   output logic [angle_spi_pkg::ANGLE_W-1:0] raw_angle, // front-end angle
   output logic [angle_spi_pkg::ANGLE_W-1:0] angle_out, // corrected angle, commutation
   output logic fuse_burn, // one-cycle burn strobe
   output logic [angle_spi_pkg::ANGLE_W-1:0] fuse_data // value to burn
);
   import angle_spi_pkg::*;

   logic [3:0] pin_raw;
   logic [3:0] pin_f;
   logic [3:0] pin_p_q;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;
   logic cs_act;
   logic cs_fall;
   logic sclk_rise;
   logic sclk_fall;
   logic [CNT_W-1:0] rcnt_q;
   logic [WORD_W-1:0] rx_q;
   logic [WORD_W-1:0] rx_word;
   logic [WORD_W-1:0] buf_q;
   logic miso_q;
   logic [6:0] ref_q;
   logic ref_wrap;
   logic [ANGLE_W-1:0] tdc_q;
   logic [ANGLE_W-1:0] raw_q;
   logic [ANGLE_W-1:0] zero_q;
   logic [ANGLE_W-1:0] corr;
   logic [ANGLE_W-1:0] angle_buf_q;
   logic [ANGLE_W-1:0] angle_out_q;
   logic [ANGLE_W-1:0] rd_val;
   logic frame_done;
   logic wr_zero;
   logic wr_burn;
   logic otp_loaded_q;
   logic fused_q;
   logic burn_q;
   logic [3:0] rd_addr;
   logic [3:0] rd_cmd;

   // link pins and the phase comparator are asynchronous to pclk
   assign pin_raw = {phase_cross, link.mosi, link.cs_n, link.sclk};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_sync
         logic [2:0] s_q;
         logic f_q;
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               s_q <= {3{PIN_IDLE[gi]}};
               f_q <= PIN_IDLE[gi];
            end
            else
            begin
               s_q <= {s_q[1:0], pin_raw[gi]};
               if (s_q[1] == s_q[2])
               begin
                  f_q <= s_q[2];
               end
            end
         end
         assign pin_f[gi] = f_q;
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_p_q <= PIN_IDLE;
      end
      else
      begin
         pin_p_q <= pin_f;
      end
   end

   assign pin_rise = pin_f & ~pin_p_q;
   assign pin_fall = ~pin_f & pin_p_q;
   assign cs_act = ~pin_f[1];
   assign cs_fall = pin_fall[1];
   // clock edges outside a selected frame are ignored
   assign sclk_rise = pin_rise[0] & cs_act; // R02
   assign sclk_fall = pin_fall[0] & cs_act; // R02
   assign rx_word = {rx_q[WORD_W-2:0], pin_f[2]};
   assign frame_done = sclk_rise && (rcnt_q == FRAME_LAST); // R01
   assign rd_cmd = rx_q[6:3];
   assign rd_addr = {rx_q[2:0], pin_f[2]};
   // only register 4 reads back; register 9 is write-only
   assign rd_val = (rd_cmd == CMD_READ && rd_addr == REG_ZERO) ? zero_q : 8'h00; // R15

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rcnt_q <= '0;
         rx_q <= '0;
         buf_q <= '0;
         miso_q <= 1'b0;
      end
      else if (cs_fall)
      begin
         rcnt_q <= '0;
         buf_q <= {angle_buf_q, 8'h00}; // R15
         miso_q <= angle_buf_q[ANGLE_W-1]; // R02
      end
      else if (sclk_rise && rcnt_q <= FRAME_LAST)
      begin
         rx_q <= rx_word; // R02
         rcnt_q <= rcnt_q + 5'h01;
         if (rcnt_q == BYTE_LAST)
         begin
            buf_q[ANGLE_W-1:0] <= rd_val; // R15
         end
      end
      else if (sclk_fall && rcnt_q != 5'h00 && rcnt_q <= FRAME_LAST)
      begin
         // first fall only opens the frame; the msb is already out
         miso_q <= buf_q[4'(FRAME_LAST - rcnt_q)]; // R02
      end
   end

   assign wr_zero = frame_done && rx_word[15:12] == CMD_WRITE
      && rx_word[11:8] == REG_ZERO; // R14
   assign wr_burn = frame_done && rx_word[15:12] == CMD_WRITE
      && rx_word[11:8] == REG_FUSE && rx_word[BURN_ZERO_BIT]; // R08

   // fuse contents are taken once, on the first edge after reset release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         otp_loaded_q <= 1'b0;
         fused_q <= 1'b0;
         zero_q <= ZERO_RESET; // R10
      end
      else if (!otp_loaded_q)
      begin
         otp_loaded_q <= 1'b1;
         fused_q <= otp_valid;
         zero_q <= otp_valid ? otp_value : ZERO_RESET; // R10
      end
      else
      begin
         if (wr_zero && !fused_q)
         begin
            zero_q <= rx_word[ANGLE_W-1:0]; // R07
         end
         if (wr_burn)
         begin
            fused_q <= 1'b1; // R08
         end
      end
   end

   // fuses burn only once; a second command is dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         burn_q <= 1'b0;
         fuse_data <= '0;
      end
      else
      begin
         burn_q <= wr_burn && !fused_q && otp_loaded_q; // R08
         if (wr_burn && !fused_q)
         begin
            fuse_data <= zero_q; // R08
         end
      end
   end

   // reference waveform of the time-to-digital converter, one 2 us period
   assign ref_wrap = (ref_q == REFRESH_LAST);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_q <= '0;
         tdc_q <= '0;
         raw_q <= '0;
      end
      else
      begin
         ref_q <= ref_wrap ? 7'h00 : ref_q + 7'h01; // R11
         if (pin_rise[3])
         begin
            // later crossing means larger phase, i.e. more clockwise
            tdc_q <= 8'((15'(ref_q) * 15'(FULL_TURN)) / 15'(REFRESH_CYC)); // R12 R13
         end
         if (ref_wrap)
         begin
            raw_q <= tdc_q; // R11
         end
      end
   end

   // 8-bit difference wraps naturally at one full turn
   assign corr = raw_q - zero_q; // R09 R18

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         angle_buf_q <= '0;
         angle_out_q <= '0;
      end
      else
      begin
         angle_out_q <= corr; // R10
         if (ref_wrap && !cs_act)
         begin
            angle_buf_q <= corr; // R16
         end
      end
   end

   assign raw_angle = raw_q;
   assign angle_out = angle_out_q;
   assign fuse_burn = burn_q;
   assign link.miso_o = miso_q;
   assign link.miso_oe = cs_act;
endmodule
`default_nettype wire

/* File: src/angle_spi_pkg.sv */
package angle_spi_pkg;
   localparam int CLK_MHZ = 50;
   localparam int WORD_W = 16;
   localparam int ANGLE_W = 8;
   localparam int CNT_W = 5;
   localparam logic [4:0] FRAME_LAST = 5'h0f;
   localparam logic [4:0] BYTE_LAST = 5'h07;
   localparam logic [3:0] CMD_WRITE = 4'h2;
   localparam logic [3:0] CMD_READ = 4'h1;
   localparam logic [3:0] REG_ZERO = 4'h4;
   localparam logic [3:0] REG_FUSE = 4'h9;
   localparam int BURN_ZERO_BIT = 4;
   localparam logic [7:0] ZERO_RESET = 8'h00;
   localparam logic [3:0] PIN_IDLE = 4'h7;
   localparam int REFRESH_NS = 2000;
   localparam int REFRESH_CYC = REFRESH_NS * CLK_MHZ / 1000;
   localparam logic [6:0] REFRESH_LAST = 7'(REFRESH_CYC - 1);
   localparam int FULL_TURN = 256;
   localparam int T_IDLE_NS = 50;
   localparam int T_CSL_NS = 50;
   localparam int T_CSH_NS = 25;
   localparam int T_IDLE_CYC = (T_IDLE_NS * CLK_MHZ + 999) / 1000;
   localparam int T_CSL_CYC = (T_CSL_NS * CLK_MHZ + 999) / 1000;
   localparam int T_CSH_CYC = (T_CSH_NS * CLK_MHZ + 999) / 1000;
   localparam int SCLK_HALF_CYC = 12;
   localparam logic [7:0] IDLE_LOAD = 8'(T_IDLE_CYC - 1);
   localparam logic [7:0] CSL_LOAD = 8'(T_CSL_CYC - 1);
   localparam logic [7:0] CSH_LOAD = 8'(T_CSH_CYC - 1);
   localparam logic [7:0] HALF_LOAD = 8'(SCLK_HALF_CYC - 1);
   localparam int APB_AW = 8;
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_RX = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
endpackage

/* File: src/spi_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   logic miso;
   // undriven line reads high, as a pull-up would give
   assign miso = miso_oe ? miso_o : 1'b1;
   modport device
   (
      input sclk,
      input cs_n,
      input mosi,
      output miso_o,
      output miso_oe
   );
   modport host
   (
      output sclk,
      output cs_n,
      output mosi,
      input miso
   );
endinterface
`default_nettype wire

/* File: src/angle_master_end.sv */
`timescale 1ns/1ps
`default_nettype none
module angle_master_end
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [angle_spi_pkg::APB_AW-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   spi_link_if.host link // serial link to the sensor
);
   import angle_spi_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL, ST_GAP} state_e;

   state_e state_q;
   logic [7:0] tmr_q;
   logic [CNT_W-1:0] ecnt_q;
   logic sclk_q;
   logic cs_n_q;
   logic mosi_q;
   logic [WORD_W-1:0] tx_q;
   logic [WORD_W-1:0] rx_q;
   logic [WORD_W-1:0] rx_word_q;
   logic done_q;
   logic [2:0] miso_s_q;
   logic miso_f_q;
   logic [31:0] prdata_q;
   logic err_q;
   logic setup;
   logic wr_acc;
   logic start;
   logic tmr_end;
   logic frame_end;

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   // a command written while a frame runs is dropped
   assign start = wr_acc && paddr == ADDR_CMD && state_q == ST_IDLE;
   assign tmr_end = (tmr_q == 8'h00);
   assign frame_end = state_q == ST_TRAIL && tmr_end;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         miso_s_q <= 3'h7;
         miso_f_q <= 1'b1;
      end
      else
      begin
         miso_s_q <= {miso_s_q[1:0], link.miso};
         if (miso_s_q[1] == miso_s_q[2])
         begin
            miso_f_q <= miso_s_q[2];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_IDLE;
         tmr_q <= '0;
         ecnt_q <= '0;
         sclk_q <= 1'b1;
         cs_n_q <= 1'b1;
         mosi_q <= 1'b1;
         tx_q <= '0;
         rx_q <= '0;
      end
      else
      begin
         tmr_q <= tmr_end ? 8'h00 : tmr_q - 8'h01;
         unique case (state_q)
            ST_IDLE:
            begin
               if (start)
               begin
                  cs_n_q <= 1'b0;
                  mosi_q <= pwdata[WORD_W-1];
                  tx_q <= {pwdata[WORD_W-2:0], 1'b0};
                  tmr_q <= CSL_LOAD; // R04
                  ecnt_q <= '0;
                  state_q <= ST_LEAD;
               end
            end
            ST_LEAD:
            begin
               if (tmr_end)
               begin
                  sclk_q <= 1'b0; // R04
                  tmr_q <= HALF_LOAD; // R05 R17
                  state_q <= ST_SHIFT;
               end
            end
            ST_SHIFT:
            begin
               if (tmr_end)
               begin
                  sclk_q <= ~sclk_q;
                  ecnt_q <= ecnt_q + 5'h01;
                  tmr_q <= HALF_LOAD; // R05 R17
                  if (!sclk_q)
                  begin
                     rx_q <= {rx_q[WORD_W-2:0], miso_f_q}; // R02
                     // rises fall on even counts, so the sixteenth rise is at count 30
                     if (ecnt_q == {FRAME_LAST[3:0], 1'b0}) // R01
                     begin
                        tmr_q <= CSH_LOAD; // R06
                        state_q <= ST_TRAIL;
                     end
                  end
                  else
                  begin
                     mosi_q <= tx_q[WORD_W-1]; // R02
                     tx_q <= {tx_q[WORD_W-2:0], 1'b0};
                  end
               end
            end
            ST_TRAIL:
            begin
               if (tmr_end)
               begin
                  cs_n_q <= 1'b1; // R06
                  tmr_q <= IDLE_LOAD; // R03
                  state_q <= ST_GAP;
               end
            end
            ST_GAP:
            begin
               if (tmr_end)
               begin
                  state_q <= ST_IDLE; // R03
               end
            end
         endcase
      end
   end

   // done sets at frame end; a new command clears it, set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_word_q <= '0;
         done_q <= 1'b0;
      end
      else
      begin
         if (frame_end)
         begin
            rx_word_q <= rx_q; // R01
         end
         done_q <= frame_end || (done_q && !start);
      end
   end

   // read data is latched in setup so the access phase needs no wait
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= '0;
         err_q <= 1'b0;
      end
      else if (setup)
      begin
         err_q <= !(paddr == ADDR_CMD || paddr == ADDR_RX || paddr == ADDR_STAT);
         prdata_q <= '0;
         if (paddr == ADDR_RX)
         begin
            prdata_q <= {16'h0000, rx_word_q};
         end
         else if (paddr == ADDR_STAT)
         begin
            prdata_q[STAT_BUSY] <= state_q != ST_IDLE;
            prdata_q[STAT_DONE] <= done_q;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = psel && penable;
   assign pslverr = psel && penable && err_q;
   assign link.sclk = sclk_q;
   assign link.cs_n = cs_n_q;
   assign link.mosi = mosi_q;
endmodule
`default_nettype wire

/* File: test/angle_link_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module angle_link_checker
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset
   input wire logic sclk, // serial clock
   input wire logic cs_n, // select
   input wire logic mosi, // master data
   input wire logic miso_o, // device data
   input wire logic miso_oe, // device drives miso
   input wire logic miso // resolved line
);
   logic sclk_q;
   logic [4:0] rises_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sclk_q <= 1'b1;
      else
         sclk_q <= sclk;
   end
   // counts rising edges seen inside one frame
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rises_q <= 5'h00;
      else if (cs_n)
         rises_q <= 5'h00;
      else if (sclk && !sclk_q)
         rises_q <= rises_q + 5'h01;
   end
   sequence s_clk_hold;
      sclk[*3];
   endsequence
   sequence s_low_phase;
      !sclk[*8];
   endsequence
   sequence s_high_phase;
      sclk[*8];
   endsequence
   sequence s_gap;
      cs_n[*3];
   endsequence
   AST_CLK_IDLE: assert property (cs_n |-> sclk)
      else $error("serial clock low while deselected");
   AST_CS_SETUP: assert property ($fell(cs_n) |-> s_clk_hold)
      else $error("clock fell too soon after select");
   AST_LOW_PHASE: assert property ($fell(sclk) |-> s_low_phase)
      else $error("clock low phase too short");
   AST_HIGH_PHASE: assert property ($rose(sclk) && !cs_n |-> s_high_phase)
      else $error("clock high phase too short");
   AST_CS_HOLD: assert property ($rose(cs_n) |-> $past(sclk, 2))
      else $error("select rose too soon after last clock rise");
   AST_GAP: assert property ($rose(cs_n) |-> s_gap)
      else $error("select high time too short");
   AST_FRAME_BITS: assert property ($rose(cs_n) |-> rises_q == 5'h10)
      else $error("frame did not hold sixteen clock rises");
   AST_MOSI_HOLD: assert property ($rose(sclk) && !cs_n |-> $stable(mosi) ##1 $stable(mosi))
      else $error("master data moved at sampling edge");
   AST_MISO_HOLD: assert property ($rose(sclk) && !cs_n |-> $stable(miso_o)[*4])
      else $error("device data moved at sampling edge");
   AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:6] miso_oe)
      else $error("device did not drive its data line");
   AST_OE_OFF: assert property ($rose(cs_n) |-> ##[1:6] (!miso_oe && miso))
      else $error("device kept driving after deselect");
endmodule
`default_nettype wire

/* File: test/angle_sensor_spi_zero_offset_test.sv */
`timescale 1ns/1ps
`default_nettype none
module angle_sensor_spi_zero_offset_test;
   import angle_spi_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic phase_cross = 1'b0;
   logic otp_valid = 1'b0;
   logic [ANGLE_W-1:0] otp_value = '0;
   logic [ANGLE_W-1:0] raw_angle;
   logic [ANGLE_W-1:0] angle_out;
   logic fuse_burn;
   logic [ANGLE_W-1:0] fuse_data;
   logic [16:0] notes[$];
   logic [7:0] zoff = 8'h00;
   logic [6:0] pc = 7'h00;
   logic [6:0] ph = 7'h20;
   int seed = 73971;
   int errors = 0;
   int checks = 0;
   spi_link_if lnk();
   angle_master_end i_angle_master_end(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(lnk));
   angle_sensor_end i_angle_sensor_end(.pclk(pclk), .presetn(presetn), .link(lnk),
      .phase_cross(phase_cross), .otp_valid(otp_valid), .otp_value(otp_value),
      .raw_angle(raw_angle),
      .angle_out(angle_out), .fuse_burn(fuse_burn), .fuse_data(fuse_data));
   angle_link_checker i_chk(.pclk(pclk), .presetn(presetn), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
      .mosi(lnk.mosi), .miso_o(lnk.miso_o), .miso_oe(lnk.miso_oe), .miso(lnk.miso));
   always #10 pclk = ~pclk;
   // phase comparator: rises ph cycles into each 100-cycle period
   always @(posedge pclk)
   begin
      pc <= (pc == 7'h63) ? 7'h00 : pc + 7'h01;
      phase_cross <= (pc >= ph);
   end
   task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
      begin
         checks++;
         if (seen !== exp)
         begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   // results pop the oldest note as they appear
   always @(posedge pclk)
   begin
      if ((psel && penable && pready === 1'b1 && !pwrite) || fuse_burn === 1'b1)
      begin
         if (notes.size() == 0)
         begin
            errors++;
            $display("FAIL result with no note");
         end
         else if (fuse_burn === 1'b1)
            chk("fuse_data", {9'h000, fuse_data}, notes.pop_front());
         else
            chk("apb_read", {pslverr, prdata[15:0]}, notes.pop_front());
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      begin
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [16:0] e);
      begin
         notes.push_back(e);
         apb(1'b0, a, 32'h00000000);
      end
   endtask
   task automatic frame(input logic [15:0] w);
      begin
         apb(1'b1, ADDR_CMD, {16'h0000, w});
         @(posedge lnk.cs_n);
         repeat (5) @(posedge pclk);
      end
   endtask
   // waits past a refresh so the frozen buffer holds the current offset
   task automatic readback(input logic [3:0] r, input logic [7:0] v);
      logic [7:0] raw;
      logic [7:0] ang;
      begin
         repeat (REFRESH_CYC + 20) @(posedge pclk);
         // stimulus period equals the converter period, so raw is the delay scaled to a turn
         raw = 8'((int'(ph) * FULL_TURN) / REFRESH_CYC);
         ang = raw - zoff;
         chk("raw_angle", {9'h000, raw_angle}, {9'h000, raw});
         chk("angle_out", {9'h000, angle_out}, {9'h000, ang});
         frame({CMD_READ, r, 8'h00});
         rd(ADDR_RX, {1'b0, ang, v});
      end
   endtask
   task automatic results();
      begin
         $display("checks %0d errors %0d", checks, errors);
         if (errors == 0 && checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   initial
   begin
      repeat (30000) @(posedge pclk);
      errors++;
      $display("FAIL watchdog expired");
      results();
   end
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (300) @(posedge pclk);
      rd(ADDR_STAT, 17'h00000);
      rd(8'h0c, 17'h10000);
      readback(REG_ZERO, ZERO_RESET);
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         ph <= 7'(($random(seed) & 32'h3f) + 1);
         zoff = (i == 2) ? 8'hff : 8'($random(seed));
         frame({CMD_WRITE, REG_ZERO, zoff});
         rd(ADDR_STAT, 17'h00002);
         repeat (REFRESH_CYC * 2) @(posedge pclk);
         readback(REG_ZERO, zoff);
      end
      $display("test offset done");
      readback(REG_FUSE, 8'h00);
      $display("test other register done");
      // second command lands while busy and must be dropped
      apb(1'b1, ADDR_CMD, {16'h0000, CMD_READ, REG_ZERO, 8'h00});
      apb(1'b1, ADDR_CMD, {16'h0000, CMD_WRITE, REG_ZERO, 8'h5a});
      rd(ADDR_STAT, 17'h00001);
      @(posedge lnk.cs_n);
      repeat (5) @(posedge pclk);
      readback(REG_ZERO, zoff);
      $display("test busy refusal done");
      notes.push_back({9'h000, zoff});
      frame({CMD_WRITE, REG_FUSE, 8'(1 << BURN_ZERO_BIT)});
      frame({CMD_WRITE, REG_ZERO, 8'h33});
      readback(REG_ZERO, zoff);
      $display("test burn done");
      // fuse memory keeps the burned offset across a power cycle
      otp_value <= zoff;
      otp_valid <= 1'b1;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      // release in step with the phase stimulus so the converter scale still holds
      while (pc != 7'h04)
         @(posedge pclk);
      presetn <= 1'b1;
      repeat (300) @(posedge pclk);
      // fused at power-up: write and a second burn must both be ignored
      frame({CMD_WRITE, REG_ZERO, 8'h11});
      frame({CMD_WRITE, REG_FUSE, 8'(1 << BURN_ZERO_BIT)});
      readback(REG_ZERO, zoff);
      $display("test power cycle done");
      results();
   end
endmodule
`default_nettype wire
